/* File: rfp_cfg.svh */
// Constants of the rail fault-protection sequencer: levels, offsets and timing counts
`ifndef RFP_CFG_SVH
`define RFP_CFG_SVH
// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define RFP_CLK_MHZ         50
`define RFP_OV_FILT_NS      500
`define RFP_UV_FILT_NS      3000
`define RFP_OC_FILT_NS      40000
`define RFP_SETTLE_NS       80000
`define RFP_OV_RAMP_DLY_NS  60000
// Least times round up to whole cycles
`define RFP_NS2CYC(ns)      (((ns) * `RFP_CLK_MHZ + 999) / 1000)
`define RFP_OV_FILT_CYC     `RFP_NS2CYC(`RFP_OV_FILT_NS)
`define RFP_UV_FILT_CYC     `RFP_NS2CYC(`RFP_UV_FILT_NS)
`define RFP_OC_FILT_CYC     `RFP_NS2CYC(`RFP_OC_FILT_NS)
`define RFP_SETTLE_CYC      `RFP_NS2CYC(`RFP_SETTLE_NS)
`define RFP_OV_RAMP_DLY_CYC `RFP_NS2CYC(`RFP_OV_RAMP_DLY_NS)
// ----------------------------------------------------------------
// Voltage levels in millivolts
// ----------------------------------------------------------------
`define RFP_OV_ZS_MV        13'h0992
`define RFP_OV_OFS_MV       13'h015E
`define RFP_OV_MIN_MV       13'h0546
`define RFP_OV_KNEE_MV      13'h03E8
`define RFP_OV_ZS_REL_MV    13'h0834
`define RFP_UV_OFS_MV       13'h028A
`define RFP_FLAG_OV_MV      13'h03E8
`define RFP_FLAG_UV_MV      13'h05DC
`define RFP_FLAG_OC_MV      13'h07D0
`define RFP_ZERO_MV         13'h0000
`endif

/* File: rfp_pkg.sv */
// Types shared by the rail fault-protection sequencer modules
package rfp_pkg;
  typedef logic [12:0] rfp_mv_t;
  typedef logic [11:0] rfp_cnt_t;

  typedef enum logic [1:0] {
    RFP_RUN     = 2'h0,
    RFP_OV_HOLD = 2'h1,
    RFP_OV_RAMP = 2'h3,
    RFP_TRIPPED = 2'h2
  } rfp_state_t;

  typedef enum logic [1:0] {
    RFP_PWM_NORMAL = 2'h0,
    RFP_PWM_LOW    = 2'h1,
    RFP_PWM_TRI    = 2'h2
  } rfp_pwm_t;

  typedef enum logic [1:0] {
    RFP_F_NONE = 2'h0,
    RFP_F_OV   = 2'h1,
    RFP_F_UV   = 2'h2,
    RFP_F_OC   = 2'h3
  } rfp_fault_t;

  // Comparator results, all synchronous to CLK
  typedef struct packed {
    logic ov;         // Sense above overvoltage threshold
    logic uv;         // Sense below undervoltage threshold
    logic below_rel;  // Sense below release level
    logic ss_oc;      // Inductor current above soft-start limit
    logic sum_oc;     // Total current above limit
  } rfp_cmp_t;

  typedef struct packed {
    rfp_cnt_t cnt;
    logic     hit;
  } rfp_flt_st_t;

  typedef struct packed {
    logic [2:0] en_s;
    logic       en_q;
    rfp_state_t st;
    rfp_pwm_t   pwm;
    logic       block_on;
    logic       good;
    rfp_fault_t fault;
    rfp_mv_t    flag_mv;
    rfp_mv_t    ov_thr;
    rfp_mv_t    uv_thr;
    rfp_mv_t    rel_thr;
    rfp_mv_t    itgt;
    logic       zs;
    logic       zs_trip;
    logic       ramp_seen;
    logic       ss_done;
    rfp_cnt_t   settle_cnt;
    rfp_cnt_t   dly_cnt;
  } rfp_seq_st_t;
endpackage

/* File: rfp_filter.sv */
// Consecutive-sample filter: asserts once the input has held for a set count
`timescale 1ns/1ps
module rfp_filter import rfp_pkg::*; #(
  parameter rfp_cnt_t COUNT = 12'h001
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic arm,
  input  wire logic sample,
  output logic      hit
);
  rfp_flt_st_t cur_ff;
  rfp_flt_st_t nxt_st;

  // ----------------------------------------------------------------
  // Counter of consecutive asserted samples
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = cur_ff;
    if (!arm || !sample) begin
      nxt_st.cnt = '0;                                 // Any gap restarts the filter
      nxt_st.hit = 1'b0;
    end else if (cur_ff.cnt != COUNT) begin
      nxt_st.cnt = cur_ff.cnt + 12'h001;
      nxt_st.hit = ((cur_ff.cnt + 12'h001) == COUNT);  // Hit on the COUNT-th sample
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else if (ce) begin
      cur_ff <= nxt_st;
    end
  end

  assign hit = cur_ff.hit;
endmodule

/* File: rfp_seq.sv */
// Fault-protection sequencer for one regulator rail
// Behaviour
// - The overvoltage comparator is ignored while the target code is zero.
// - From a ramp-up from zero until the first PWM pulse after settling, the overvoltage threshold is 2.45 V.
// - Otherwise the overvoltage threshold is target plus 350 mV, but 1.35 V when the target is 1.0 V or less.
// - Overvoltage held 0.5 us drops ready and drives every PWM low.
// - After an overvoltage trip PWM stays low until the output is below 2.1 V (zero-start ramp) or the target.
// - 60 us after an overvoltage trip the internal target ramps slowly to zero and PWM on-pulses are blocked.
// - During that ramp-down each PWM is held low or tri-state so the output follows the falling target.
// - Output below target minus 650 mV for 3 us trips undervoltage, drops ready and tri-states PWM.
// - Undervoltage detection is masked during a target transition and 80 us after it settles.
// - Every protection stays latched with ready low until the supply or enable input toggles.
// - The reference flag level is forced to 1 V, 1.5 V or 2 V for overvoltage, undervoltage, overcurrent.
// - Soft-start overcurrent is checked only in the first ramp from zero plus 80 us, and trips everything off.
// - Total overcurrent trips after 40 us, is masked in transitions plus 80 us and at zero target.
`timescale 1ns/1ps
`include "rfp_cfg.svh"
module rfp_seq import rfp_pkg::*; #(
  parameter rfp_cnt_t SLEW_CYC = 12'h032   // Cycles per 1 mV step of the slow ramp-down
) (
  input  wire logic     CLK,
  input  wire logic     RESETN,
  input  wire logic     CE,
  input  wire logic     RAIL_ENABLE,
  input  wire rfp_mv_t  TARGET_VOLTAGE_CODE,
  input  wire logic     TARGET_TRANSITION,
  input  wire logic     PWM_PULSE,
  input  wire rfp_cmp_t CMP,
  output rfp_mv_t       OV_THRESHOLD_MV,
  output rfp_mv_t       UV_THRESHOLD_MV,
  output rfp_mv_t       RELEASE_MV,
  output rfp_mv_t       INTERNAL_TARGET_MV,
  output rfp_pwm_t      PWM_MODE,
  output logic          PWM_ON_BLOCK,
  output logic          RAIL_POWER_GOOD_OUT,
  output rfp_fault_t    FAULT_KIND,
  output rfp_mv_t       REF_FLAG_MV
);
  localparam rfp_cnt_t OV_FILT   = 12'(`RFP_OV_FILT_CYC);
  localparam rfp_cnt_t UV_FILT   = 12'(`RFP_UV_FILT_CYC);
  localparam rfp_cnt_t OC_FILT   = 12'(`RFP_OC_FILT_CYC);
  localparam rfp_cnt_t SETTLE    = 12'(`RFP_SETTLE_CYC);
  localparam rfp_cnt_t RAMP_DLY  = 12'(`RFP_OV_RAMP_DLY_CYC);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;

  // Two stages so release never lands near an edge
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  rfp_seq_st_t cur_ff;
  rfp_seq_st_t nxt_st;

  // ----------------------------------------------------------------
  // Masks and filters
  // ----------------------------------------------------------------
  logic tgt_zero;
  logic settled;
  logic ov_arm;
  logic uv_arm;
  logic ss_arm;
  logic oc_arm;
  logic ov_hit;
  logic uv_hit;
  logic ss_hit;
  logic oc_hit;

  assign tgt_zero = (TARGET_VOLTAGE_CODE == `RFP_ZERO_MV);
  assign settled  = !TARGET_TRANSITION && (cur_ff.settle_cnt == SETTLE);
  // Filters only run while the rail is enabled and running
  assign ov_arm   = cur_ff.en_q && (cur_ff.st == RFP_RUN) && !tgt_zero;
  assign uv_arm   = cur_ff.en_q && (cur_ff.st == RFP_RUN) && settled && !tgt_zero;
  // Soft-start check waits for the ramp to leave zero; a rail held at zero has nothing to protect
  assign ss_arm   = cur_ff.en_q && (cur_ff.st == RFP_RUN) && !cur_ff.ss_done && !tgt_zero;
  assign oc_arm   = cur_ff.en_q && (cur_ff.st == RFP_RUN) && settled && !tgt_zero;

  rfp_filter #(.COUNT(OV_FILT)) u_ov_flt (
    .clk    (CLK),
    .rst_n  (rst_n_ff),
    .ce     (CE),
    .arm    (ov_arm),
    .sample (CMP.ov),
    .hit    (ov_hit)
  );
  rfp_filter #(.COUNT(UV_FILT)) u_uv_flt (
    .clk    (CLK),
    .rst_n  (rst_n_ff),
    .ce     (CE),
    .arm    (uv_arm),
    .sample (CMP.uv),
    .hit    (uv_hit)
  );
  // Soft-start trip acts at once; one sample is the least the filter can take
  rfp_filter #(.COUNT(12'h001)) u_ss_flt (
    .clk    (CLK),
    .rst_n  (rst_n_ff),
    .ce     (CE),
    .arm    (ss_arm),
    .sample (CMP.ss_oc),
    .hit    (ss_hit)
  );
  rfp_filter #(.COUNT(OC_FILT)) u_oc_flt (
    .clk    (CLK),
    .rst_n  (rst_n_ff),
    .ce     (CE),
    .arm    (oc_arm),
    .sample (CMP.sum_oc),
    .hit    (oc_hit)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = cur_ff;
    // Enable pin: three stages, a change counts once stages two and three agree
    nxt_st.en_s = {cur_ff.en_s[1:0], RAIL_ENABLE};
    if (cur_ff.en_s[2] == cur_ff.en_s[1]) begin
      nxt_st.en_q = cur_ff.en_s[2];
    end

    // Settle counter restarts on every transition and at zero target
    if (TARGET_TRANSITION || tgt_zero) begin
      nxt_st.settle_cnt = '0;
    end else if (cur_ff.settle_cnt != SETTLE) begin
      nxt_st.settle_cnt = cur_ff.settle_cnt + 12'h001;
    end

    // Zero-start window opens when a ramp leaves zero, closes on first pulse after settling
    if (cur_ff.st == RFP_RUN) begin
      if (tgt_zero) begin
        nxt_st.zs = 1'b1;
      end else if (cur_ff.zs && !TARGET_TRANSITION && PWM_PULSE) begin
        nxt_st.zs = 1'b0;
      end
      if (!tgt_zero) begin
        nxt_st.ramp_seen = 1'b1;
      end
      if (cur_ff.ramp_seen && settled) begin
        nxt_st.ss_done = 1'b1;
      end
      nxt_st.itgt = TARGET_VOLTAGE_CODE;
    end

    // Overvoltage threshold follows the target
    if (cur_ff.zs) begin
      nxt_st.ov_thr = `RFP_OV_ZS_MV;
    end else if (TARGET_VOLTAGE_CODE > `RFP_OV_KNEE_MV) begin
      nxt_st.ov_thr = TARGET_VOLTAGE_CODE + `RFP_OV_OFS_MV;
    end else begin
      nxt_st.ov_thr = `RFP_OV_MIN_MV;
    end
    // Undervoltage threshold saturates at zero
    if (TARGET_VOLTAGE_CODE > `RFP_UV_OFS_MV) begin
      nxt_st.uv_thr = TARGET_VOLTAGE_CODE - `RFP_UV_OFS_MV;
    end else begin
      nxt_st.uv_thr = `RFP_ZERO_MV;
    end
    // Release level: fixed after a zero-start trip, else the (falling) internal target
    nxt_st.rel_thr = cur_ff.zs_trip ? `RFP_OV_ZS_REL_MV : cur_ff.itgt;

    unique case (cur_ff.st)
      RFP_RUN: begin
        nxt_st.pwm      = RFP_PWM_NORMAL;
        nxt_st.block_on = 1'b0;
        nxt_st.good     = cur_ff.en_q && settled && !tgt_zero;
        // Overvoltage takes priority as it needs active pull-down
        if (ov_hit) begin
          nxt_st.st      = RFP_OV_HOLD;
          nxt_st.pwm     = RFP_PWM_LOW;
          nxt_st.good    = 1'b0;
          nxt_st.fault   = RFP_F_OV;
          nxt_st.flag_mv = `RFP_FLAG_OV_MV;
          nxt_st.zs_trip = cur_ff.zs;
          nxt_st.dly_cnt = '0;
        end else if (ss_hit || oc_hit) begin
          nxt_st.st      = RFP_TRIPPED;
          nxt_st.pwm     = RFP_PWM_TRI;
          nxt_st.good    = 1'b0;
          nxt_st.fault   = RFP_F_OC;
          nxt_st.flag_mv = `RFP_FLAG_OC_MV;
        end else if (uv_hit) begin
          nxt_st.st      = RFP_TRIPPED;
          nxt_st.pwm     = RFP_PWM_TRI;
          nxt_st.good    = 1'b0;
          nxt_st.fault   = RFP_F_UV;
          nxt_st.flag_mv = `RFP_FLAG_UV_MV;
        end
      end
      RFP_OV_HOLD: begin
        // Low until the output drops below the release level, then let go
        nxt_st.pwm     = CMP.below_rel ? RFP_PWM_TRI : RFP_PWM_LOW;
        nxt_st.dly_cnt = cur_ff.dly_cnt + 12'h001;
        if (cur_ff.dly_cnt == RAMP_DLY - 12'h001) begin
          nxt_st.st       = RFP_OV_RAMP;
          nxt_st.block_on = 1'b1;
          nxt_st.dly_cnt  = '0;
          nxt_st.zs_trip  = 1'b0;
        end
      end
      RFP_OV_RAMP: begin
        // Slow fixed slew; pulls down only while the output is above the target
        nxt_st.block_on = 1'b1;
        nxt_st.pwm      = CMP.below_rel ? RFP_PWM_TRI : RFP_PWM_LOW;
        if (cur_ff.itgt != `RFP_ZERO_MV) begin
          if (cur_ff.dly_cnt == SLEW_CYC - 12'h001) begin
            nxt_st.dly_cnt = '0;
            nxt_st.itgt    = cur_ff.itgt - 13'h0001;
          end else begin
            nxt_st.dly_cnt = cur_ff.dly_cnt + 12'h001;
          end
        end
      end
      RFP_TRIPPED: begin
        nxt_st.pwm = RFP_PWM_TRI;
      end
    endcase

    // An enable toggle or a reset clears a latched protection; hold ready low meanwhile
    if (!cur_ff.en_q) begin
      nxt_st.st        = RFP_RUN;
      nxt_st.pwm       = RFP_PWM_TRI;
      nxt_st.block_on  = 1'b0;
      nxt_st.good      = 1'b0;
      nxt_st.fault     = RFP_F_NONE;
      nxt_st.flag_mv   = `RFP_ZERO_MV;
      nxt_st.zs_trip   = 1'b0;
      nxt_st.ramp_seen = 1'b0;
      nxt_st.ss_done   = 1'b0;
      nxt_st.zs        = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cur_ff     <= '0;
      cur_ff.pwm <= RFP_PWM_TRI;
      cur_ff.zs  <= 1'b1;
    end else if (CE) begin
      cur_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign OV_THRESHOLD_MV     = cur_ff.ov_thr;
  assign UV_THRESHOLD_MV     = cur_ff.uv_thr;
  assign RELEASE_MV          = cur_ff.rel_thr;
  assign INTERNAL_TARGET_MV  = cur_ff.itgt;
  assign PWM_MODE            = cur_ff.pwm;
  assign PWM_ON_BLOCK        = cur_ff.block_on;
  assign RAIL_POWER_GOOD_OUT = cur_ff.good;
  assign FAULT_KIND          = cur_ff.fault;
  assign REF_FLAG_MV         = cur_ff.flag_mv;
endmodule

/* File: rfp_seq_asserts.sv */
// Port-level assertions for the rail fault-protection sequencer
`timescale 1ns/1ps
`include "rfp_cfg.svh"
module rfp_seq_asserts import rfp_pkg::*; #(
  parameter rfp_cnt_t SLEW_CYC = 12'h032
) (
  input wire logic       CLK,
  input wire logic       RESETN,
  input wire logic       CE,
  input wire logic       RAIL_ENABLE,
  input wire rfp_mv_t    TARGET_VOLTAGE_CODE,
  input wire logic       TARGET_TRANSITION,
  input wire logic       PWM_PULSE,
  input wire rfp_cmp_t   CMP,
  input wire rfp_mv_t    OV_THRESHOLD_MV,
  input wire rfp_mv_t    UV_THRESHOLD_MV,
  input wire rfp_mv_t    RELEASE_MV,
  input wire rfp_mv_t    INTERNAL_TARGET_MV,
  input wire rfp_pwm_t   PWM_MODE,
  input wire logic       PWM_ON_BLOCK,
  input wire logic       RAIL_POWER_GOOD_OUT,
  input wire rfp_fault_t FAULT_KIND,
  input wire rfp_mv_t    REF_FLAG_MV
);
  logic [12:0] quiet_ff;
  logic [12:0] ov_age_ff;
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  // Saturating, so a long quiet run never wraps back into the mask
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      quiet_ff  <= 13'h0000;
      ov_age_ff <= 13'h0000;
    end else begin
      quiet_ff  <= (TARGET_TRANSITION || TARGET_VOLTAGE_CODE == 13'h0000) ? 13'h0000 : quiet_ff + {12'h000, ~&quiet_ff};
      ov_age_ff <= (FAULT_KIND == RFP_F_OV) ? ov_age_ff + {12'h000, ~&ov_age_ff} : 13'h0000;
    end
  end
  default clocking dcb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  property p_ov_act;
    (FAULT_KIND == RFP_F_OV && $past(FAULT_KIND) == RFP_F_NONE) |-> PWM_MODE == RFP_PWM_LOW && !RAIL_POWER_GOOD_OUT;
  endproperty
  a_ov_act: assert property (p_ov_act) else $error("overvoltage action wrong");
  property p_flag;
    FAULT_KIND != RFP_F_NONE |-> REF_FLAG_MV == (FAULT_KIND == RFP_F_OV ? `RFP_FLAG_OV_MV :
      FAULT_KIND == RFP_F_UV ? `RFP_FLAG_UV_MV : `RFP_FLAG_OC_MV);
  endproperty
  a_flag: assert property (p_flag) else $error("flag level wrong");
  property p_uv_act;
    FAULT_KIND == RFP_F_UV |-> PWM_MODE == RFP_PWM_TRI && !RAIL_POWER_GOOD_OUT;
  endproperty
  a_uv_act: assert property (p_uv_act) else $error("undervoltage action wrong");
  property p_oc_act;
    FAULT_KIND == RFP_F_OC |-> PWM_MODE == RFP_PWM_TRI && !RAIL_POWER_GOOD_OUT;
  endproperty
  a_oc_act: assert property (p_oc_act) else $error("overcurrent action wrong");
  property p_latch;
    (FAULT_KIND != RFP_F_NONE && RAIL_ENABLE && $past(RAIL_ENABLE) && $past(RAIL_ENABLE, 2) && $past(RAIL_ENABLE, 3))
      |=> $stable(FAULT_KIND) && !RAIL_POWER_GOOD_OUT;
  endproperty
  a_latch: assert property (p_latch) else $error("fault latch released");
  property p_uv_mask;
    (FAULT_KIND == RFP_F_UV && $past(FAULT_KIND) == RFP_F_NONE) |-> quiet_ff >= 13'h0FA0;
  endproperty
  a_uv_mask: assert property (p_uv_mask) else $error("undervoltage inside mask");
  property p_block;
    $rose(PWM_ON_BLOCK) |-> FAULT_KIND == RFP_F_OV && ov_age_ff >= 13'h0BB3 && ov_age_ff <= 13'h0BBD;
  endproperty
  a_block: assert property (p_block) else $error("ramp-down start time wrong");
  property p_ov_thr;
    (RAIL_POWER_GOOD_OUT && $stable(TARGET_VOLTAGE_CODE)) |-> OV_THRESHOLD_MV == `RFP_OV_ZS_MV ||
      OV_THRESHOLD_MV == (TARGET_VOLTAGE_CODE > `RFP_OV_KNEE_MV ? TARGET_VOLTAGE_CODE + `RFP_OV_OFS_MV : `RFP_OV_MIN_MV);
  endproperty
  a_ov_thr: assert property (p_ov_thr) else $error("overvoltage threshold wrong");
  c_ramp: cover property ($rose(PWM_ON_BLOCK));
  c_uv: cover property (FAULT_KIND == RFP_F_UV);
  c_oc: cover property (FAULT_KIND == RFP_F_OC);
endmodule
bind rfp_seq rfp_seq_asserts #(.SLEW_CYC(SLEW_CYC)) u_chk (.CLK(CLK), .RESETN(RESETN), .CE(CE),
  .RAIL_ENABLE(RAIL_ENABLE), .TARGET_VOLTAGE_CODE(TARGET_VOLTAGE_CODE), .TARGET_TRANSITION(TARGET_TRANSITION),
  .PWM_PULSE(PWM_PULSE), .CMP(CMP), .OV_THRESHOLD_MV(OV_THRESHOLD_MV), .UV_THRESHOLD_MV(UV_THRESHOLD_MV),
  .RELEASE_MV(RELEASE_MV), .INTERNAL_TARGET_MV(INTERNAL_TARGET_MV), .PWM_MODE(PWM_MODE),
  .PWM_ON_BLOCK(PWM_ON_BLOCK), .RAIL_POWER_GOOD_OUT(RAIL_POWER_GOOD_OUT), .FAULT_KIND(FAULT_KIND),
  .REF_FLAG_MV(REF_FLAG_MV));

/* File: rfp_rail_model.sv */
// Behavioural rail model: sense level and current flags to comparator results
`timescale 1ns/1ps
module rfp_rail_model import rfp_pkg::*; (
  input  wire logic    clk,
  input  wire rfp_mv_t sense_mv,
  input  wire logic    ss_oc_in,
  input  wire logic    sum_oc_in,
  input  wire rfp_mv_t ov_thr,
  input  wire rfp_mv_t uv_thr,
  input  wire rfp_mv_t rel_thr,
  output rfp_cmp_t     cmp
);
  // Compare once per cycle so the sequencer sees clean synchronous levels
  always_ff @(posedge clk) begin
    cmp <= {sense_mv > ov_thr, sense_mv < uv_thr, sense_mv < rel_thr, ss_oc_in, sum_oc_in};
  end
endmodule

/* File: test_rfp_seq.sv */
// Self-checking testbench for the rail fault-protection sequencer
`timescale 1ns/1ps
`include "rfp_cfg.svh"
module test_rfp_seq import rfp_pkg::*;;
  logic       clk, resetn, en, tr, pulse, ss, sum, blk, good;
  rfp_mv_t    tgt, sense, ov_thr, uv_thr, rel_thr, itgt, flag;
  rfp_cmp_t   cmp;
  rfp_pwm_t   pwm;
  rfp_fault_t fault;
  int         num_errors, n_tests;
  rfp_seq dut (.CLK(clk), .RESETN(resetn), .CE(1'b1), .RAIL_ENABLE(en), .TARGET_VOLTAGE_CODE(tgt),
    .TARGET_TRANSITION(tr), .PWM_PULSE(pulse), .CMP(cmp), .OV_THRESHOLD_MV(ov_thr), .UV_THRESHOLD_MV(uv_thr),
    .RELEASE_MV(rel_thr), .INTERNAL_TARGET_MV(itgt), .PWM_MODE(pwm), .PWM_ON_BLOCK(blk),
    .RAIL_POWER_GOOD_OUT(good), .FAULT_KIND(fault), .REF_FLAG_MV(flag));
  rfp_rail_model model (.clk(clk), .sense_mv(sense), .ss_oc_in(ss), .sum_oc_in(sum), .ov_thr(ov_thr),
    .uv_thr(uv_thr), .rel_thr(rel_thr), .cmp(cmp));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask
  task automatic chf(input rfp_fault_t e);
    chk("fault", 13'(fault), 13'(e));
  endtask
  task automatic chp(input rfp_pwm_t e);
    chk("pwm", 13'(pwm), 13'(e));
  endtask
  // Inputs always move 1 ns after the edge, clear of sampling
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic power_up();
    resetn = 1'b0;
    en = 1'b0;
    step(2);
    chp(RFP_PWM_TRI);
    resetn = 1'b1;
    en = 1'b1;
    step(10);
  endtask
  // Transition, settle, first on-pulse, then wait out the settle mask
  task automatic ramp(input rfp_mv_t v);
    tr = 1'b1;
    tgt = v;
    step(5);
    tr = 1'b0;
    step(5);
    pulse = 1'b1;
    step(1);
    pulse = 1'b0;
    sense = v;
    step(4100);
  endtask
  task automatic toggle();
    en = 1'b0;
    step(10);
    chf(RFP_F_NONE);
    en = 1'b1;
    step(10);
  endtask
  task automatic t_start();
    sense = 13'h0BB8;
    step(60);
    chf(RFP_F_NONE);
    sense = 13'h0000;
    tr = 1'b1;
    tgt = 13'h0384;
    step(5);
    chk("ov_thr_zs", ov_thr, `RFP_OV_ZS_MV);
    ramp(13'h0384);
    chk("ov_thr_lo", ov_thr, 13'h0546);
    chk("uv_thr", uv_thr, 13'h00FA);
    chk("good", 13'(good), 13'h0001);
  endtask
  task automatic t_ov();
    ramp(13'h04B0);
    chk("ov_thr_hi", ov_thr, 13'h060E);
    sense = 13'h0618;
    step(20);
    sense = 13'h04B0;
    step(5);
    chf(RFP_F_NONE);
    sense = 13'h0618;
    step(35);
    chf(RFP_F_OV);
    chp(RFP_PWM_LOW);
    chk("flag_ov", flag, 13'h03E8);
    chk("rel", rel_thr, 13'h04B0);
    sense = 13'h044C;
    step(3);
    chp(RFP_PWM_TRI);
    step(3000);
    chk("block", 13'(blk), 13'h0001);
    sense = 13'h04B0;
    step(300);
    chk("itgt_fall", 13'(itgt < 13'h04B0), 13'h0001);
    chp(RFP_PWM_LOW);
    chf(RFP_F_OV);
  endtask
  task automatic t_uv();
    tr = 1'b1;
    tgt = 13'h03E8;
    sense = 13'h00C8;
    step(5);
    tr = 1'b0;
    step(3000);
    chf(RFP_F_NONE);
    step(1300);
    chf(RFP_F_UV);
    chp(RFP_PWM_TRI);
    chk("flag_uv", flag, 13'h05DC);
  endtask
  task automatic t_oc();
    ramp(13'h03E8);
    sum = 1'b1;
    step(1990);
    chf(RFP_F_NONE);
    step(20);
    chf(RFP_F_OC);
    chp(RFP_PWM_TRI);
    chk("flag_oc", flag, 13'h07D0);
    sum = 1'b0;
  endtask
  task automatic t_ss();
    tgt = 13'h0000;
    power_up();
    sum = 1'b1;
    ss = 1'b1;
    step(2100);
    chf(RFP_F_NONE);
    sum = 1'b0;
    ss = 1'b0;
    tr = 1'b1;
    tgt = 13'h03E8;
    step(5);
    ss = 1'b1;
    step(4);
    chf(RFP_F_OC);
    chk("good_ss", 13'(good), 13'h0000);
    ss = 1'b0;
    resetn = 1'b0;
    step(1);
    chf(RFP_F_NONE);
  endtask
  // Trip inside the zero-start window: release at the fixed level, not at the target
  task automatic t_zs_ov();
    tr = 1'b1;
    sense = 13'h0960;
    step(40);
    chf(RFP_F_NONE);
    sense = 13'h09C4;
    step(40);
    chf(RFP_F_OV);
    chk("rel_zs", rel_thr, 13'h0834);
    chp(RFP_PWM_LOW);
    sense = 13'h07D0;
    step(3);
    chp(RFP_PWM_TRI);
    tr = 1'b0;
  endtask
  // Watchdog: the scenarios need about 25k cycles
  initial begin
    #1000000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    {resetn, en, tr, pulse, ss, sum} = 6'h00;
    tgt = 13'h0000;
    sense = 13'h0000;
    power_up();
    t_start();
    t_ov();
    toggle();
    t_uv();
    toggle();
    t_oc();
    toggle();
    t_zs_ov();
    t_ss();
    report_and_stop();
  end
endmodule
